/* hdl/tmcr_defs.svh */
// Register map, field positions, reset values and timing of the temperature monitor
`ifndef TMCR_DEFS_SVH
`define TMCR_DEFS_SVH

// Temperature data, high byte then low byte per channel
`define TMCR_ADDR_INT_HI     8'h00
`define TMCR_ADDR_INT_LO     8'h23
`define TMCR_ADDR_R1_HI      8'h01
`define TMCR_ADDR_R1_LO      8'h10
`define TMCR_ADDR_R2_HI      8'hf8
`define TMCR_ADDR_R2_LO      8'hf9
`define TMCR_ADDR_X1_HI      8'hfa
`define TMCR_ADDR_X1_LO      8'hfb
`define TMCR_ADDR_X2_HI      8'hfc
`define TMCR_ADDR_X2_LO      8'hfd

// Control and status
`define TMCR_ADDR_STATUS     8'h02
`define TMCR_ADDR_CFG_RD     8'h03
`define TMCR_ADDR_CFG_WR     8'h09
`define TMCR_ADDR_XCFG       8'h04
`define TMCR_ADDR_ONESHOT    8'h0f

`define TMCR_STATUS_RESET    8'h00
`define TMCR_CFG_RESET       8'h45
`define TMCR_XCFG_RESET      8'h09
`define TMCR_ONESHOT_READ    8'h00
`define TMCR_UNDEF_READ      8'h00

// Field positions
`define TMCR_ST_BUSY         7
`define TMCR_ST_WARMER       4
`define TMCR_ST_R2_FAULT     1
`define TMCR_ST_R1_FAULT     0
`define TMCR_CFG_STANDBY     6
`define TMCR_XCFG_DEPTH      3
`define TMCR_XCFG_DA_DIS     2
`define TMCR_XCFG_WARMER     1
`define TMCR_XCFG_REC        0

// Conversion rate codes
`define TMCR_CR_2HZ          3'h4
`define TMCR_CR_4HZ          3'h5
`define TMCR_CR_8HZ          3'h6
`define TMCR_CR_16HZ         3'h7

// Extended format offset: 64 degrees in eighths
`define TMCR_EXT_OFFSET      12'h200

// Timing
`define TMCR_CLK_PERIOD_NS        100
`define TMCR_CONV_PERIOD_1HZ_NS   1000000000

// Two-wire slave address, arbitrary value
`define TMCR_DEV_ADDR        7'h2a

`endif

/* hdl/tmcr_pkg.sv */
// Types shared by the temperature monitor modules
package tmcr_pkg;

  typedef enum logic [3:0] {
    TMCR_TW_IDLE, TMCR_TW_ADDR, TMCR_TW_ADDR_ACK, TMCR_TW_PTR, TMCR_TW_PTR_ACK,
    TMCR_TW_WDATA, TMCR_TW_WDATA_ACK, TMCR_TW_RDATA, TMCR_TW_RDATA_ACK
  } tmcr_tw_state_t;

  typedef enum logic {TMCR_SEQ_IDLE, TMCR_SEQ_WAIT} tmcr_seq_state_t;

  typedef enum logic [1:0] {TMCR_CH_INT, TMCR_CH_R1, TMCR_CH_R2} tmcr_chan_t;

  typedef enum logic [1:0] {TMCR_AVG_1X, TMCR_AVG_2X, TMCR_AVG_4X} tmcr_avg_t;

  typedef struct packed {
    logic           scl_s1;
    logic           scl_s2;
    logic           scl_s3;
    logic           sda_s1;
    logic           sda_s2;
    logic           sda_s3;
    tmcr_tw_state_t state;
    logic [3:0]     bitcnt;
    logic [7:0]     shreg;
    logic           rw;
    logic           more;
    logic           drive;
    logic [7:0]     pointer;
    logic           wr_pulse;
    logic [7:0]     wr_data;
  } tmcr_tw_regs_t;

  typedef struct packed {
    logic             standby;
    logic [2:0]       cr;
    logic [3:0]       xcfg;
    logic [2:0][10:0] leg;
    logic [1:0][10:0] ext;
    logic [4:0][2:0]  shadow;
    logic [10:0]      r1_last;
    logic             r1_fault;
    logic             r2_fault;
    logic             warmer;
    logic             busy;
    tmcr_seq_state_t  seq;
    tmcr_chan_t       chan;
    logic [31:0]      timer;
    logic             meas_req;
    tmcr_chan_t       meas_channel;
    tmcr_avg_t        meas_avg;
    logic             meas_rec_en;
  } tmcr_main_regs_t;

endpackage

/* hdl/tmcr_twowire_slave.sv */
// Two-wire management bus slave: byte pointer, repeated writes and repeated reads, all at that one pointer
`timescale 1ns/1ns
module tmcr_twowire_slave import tmcr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input  wire logic       clk,       // System clock
  input  wire logic       reset_n,   // Asynchronous reset, active low
  input  wire logic       ce,        // Clock enable, freezes state when low
  input  wire logic       scl_in,    // Bus clock pin
  input  wire logic       sda_in,    // Bus data pin level
  output logic            sda_oe_n,  // Data pin pulled low while this is low
  output logic            rd_req,    // Read byte being loaded this cycle
  output logic [7:0]      rd_addr,   // Register pointer for reads
  input  wire logic [7:0] rd_data,   // Register contents at rd_addr
  output logic            wr_pulse,  // One-cycle register write
  output logic [7:0]      wr_addr,   // Register pointer for writes
  output logic [7:0]      wr_data    // Written byte
);

  tmcr_tw_regs_t r;
  tmcr_tw_regs_t nx;
  logic          scl_rise;
  logic          scl_fall;
  logic          bus_start;
  logic          bus_stop;

  always_comb begin
    nx          = r;
    rd_req      = 1'b0;
    nx.wr_pulse = 1'b0;
    nx.scl_s1   = scl_in;
    nx.scl_s2   = r.scl_s1;
    nx.scl_s3   = r.scl_s2;
    nx.sda_s1   = sda_in;
    nx.sda_s2   = r.sda_s1;
    nx.sda_s3   = r.sda_s2;
    scl_rise    = r.scl_s2 & ~r.scl_s3;
    scl_fall    = ~r.scl_s2 & r.scl_s3;
    bus_start   = r.scl_s2 & r.scl_s3 & r.sda_s3 & ~r.sda_s2;
    bus_stop    = r.scl_s2 & r.scl_s3 & ~r.sda_s3 & r.sda_s2;
    if (bus_start) begin
      nx.state  = TMCR_TW_ADDR;
      nx.bitcnt = 4'h0;
      nx.drive  = 1'b0;
    end else if (bus_stop) begin
      nx.state = TMCR_TW_IDLE;
      nx.drive = 1'b0;
    end else begin
      case (r.state)
        TMCR_TW_ADDR, TMCR_TW_PTR, TMCR_TW_WDATA: begin
          if (scl_rise) begin
            nx.shreg  = {r.shreg[6:0], r.sda_s2};
            nx.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == 4'h8) begin
            nx.bitcnt = 4'h0;
            nx.drive  = 1'b1;
            case (r.state)
              TMCR_TW_ADDR: begin
                if (r.shreg[7:1] == DEV_ADDR) begin
                  nx.rw    = r.shreg[0];
                  nx.state = TMCR_TW_ADDR_ACK;
                end else begin
                  nx.drive = 1'b0;
                  nx.state = TMCR_TW_IDLE;
                end
              end
              TMCR_TW_PTR: begin
                nx.pointer = r.shreg;
                nx.state   = TMCR_TW_PTR_ACK;
              end
              default: begin
                nx.wr_pulse = 1'b1;
                nx.wr_data  = r.shreg;
                nx.state    = TMCR_TW_WDATA_ACK;
              end
            endcase
          end
        end
        TMCR_TW_ADDR_ACK, TMCR_TW_PTR_ACK, TMCR_TW_WDATA_ACK: begin
          if (scl_fall) begin
            nx.drive  = 1'b0;
            nx.bitcnt = 4'h0;
            if (r.state == TMCR_TW_ADDR_ACK && r.rw) begin
              rd_req   = 1'b1;
              nx.shreg = rd_data;
              nx.drive = ~rd_data[7];
              nx.state = TMCR_TW_RDATA;
            end else if (r.state == TMCR_TW_ADDR_ACK) begin
              nx.state = TMCR_TW_PTR;
            end else begin
              nx.state = TMCR_TW_WDATA;
            end
          end
        end
        TMCR_TW_RDATA: begin
          if (scl_rise) begin
            nx.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (r.bitcnt == 4'h8) begin
              nx.drive  = 1'b0;
              nx.bitcnt = 4'h0;
              nx.state  = TMCR_TW_RDATA_ACK;
            end else begin
              nx.shreg = {r.shreg[6:0], 1'b0};
              nx.drive = ~r.shreg[6];
            end
          end
        end
        TMCR_TW_RDATA_ACK: begin
          if (scl_rise) begin
            nx.more = ~r.sda_s2;
          end else if (scl_fall) begin
            if (r.more) begin
              rd_req   = 1'b1;
              nx.shreg = rd_data;
              nx.drive = ~rd_data[7];
              nx.state = TMCR_TW_RDATA;
            end else begin
              nx.state = TMCR_TW_IDLE;
            end
          end
        end
        TMCR_TW_IDLE: begin
          nx.drive = 1'b0;
        end
        default: begin
          nx.state = TMCR_TW_IDLE;
          nx.drive = 1'b0;
        end
      endcase
    end
    rd_req = rd_req & ce;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r        <= '0;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_s3 <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_s3 <= 1'b1;
    end else if (ce) begin
      r <= nx;
    end
  end

  assign sda_oe_n = ~r.drive;
  assign rd_addr  = r.pointer;
  assign wr_pulse = r.wr_pulse & ce;
  assign wr_addr  = r.pointer;
  assign wr_data  = r.wr_data;

endmodule // tmcr_twowire_slave

/* hdl/tmcr_temp_monitor.sv */
// Control/status registers and conversion sequencer of the temperature monitor
`timescale 1ns/1ns
`include "tmcr_defs.svh"
module tmcr_temp_monitor import tmcr_pkg::*; #(
  parameter int unsigned PERIOD_1HZ_CYCLES = `TMCR_CONV_PERIOD_1HZ_NS / `TMCR_CLK_PERIOD_NS,
  parameter logic [6:0]  DEV_ADDR          = `TMCR_DEV_ADDR
) (
  input  wire logic        clk,           // System clock, 10 MHz
  input  wire logic        reset_n,       // Asynchronous reset, active low
  input  wire logic        ce,            // Clock enable, freezes state when low
  input  wire logic        scl_in,        // Management bus clock pin
  input  wire logic        sda_in,        // Management bus data pin level
  output logic             sda_out,       // Data pin drive level, always low
  output logic             sda_oe_n,      // Data pin driven while low
  output logic             meas_req,      // One-cycle measurement request
  output logic [1:0]       meas_channel,  // Channel to measure
  output logic [1:0]       meas_avg,      // Averaging factor code
  output logic             meas_rec_en,   // Series-resistance correction on
  input  wire logic        meas_done,     // One-cycle measurement done
  input  wire logic [10:0] meas_result,   // Reading, two's complement eighths
  input  wire logic        meas_fault     // Diode fault seen in this measurement
);

  localparam logic [7:0] CFG_RST  = `TMCR_CFG_RESET;
  localparam logic [7:0] XCFG_RST = `TMCR_XCFG_RESET;

  if (PERIOD_1HZ_CYCLES < 32) begin : g_period_check
    $error("PERIOD_1HZ_CYCLES too small for the fastest rate");
  end
  if (PERIOD_1HZ_CYCLES % 16 != 0) begin : g_period_div
    $error("PERIOD_1HZ_CYCLES must divide by 16 for every rate");
  end
  if (DEV_ADDR == 7'h00) begin : g_addr_check
    $error("DEV_ADDR 0 is the general call address");
  end

  tmcr_main_regs_t r;
  tmcr_main_regs_t nx;
  logic            rd_req;
  logic [7:0]      rd_addr;
  logic [7:0]      rd_data;
  logic            wr_pulse;
  logic [7:0]      wr_addr;
  logic [7:0]      wr_data;
  logic            tick;
  logic            oneshot;
  logic            start;
  logic [10:0]     r2_value;
  logic            r2_hotter;

  tmcr_twowire_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_slave (
    .clk      (clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_oe_n (sda_oe_n),
    .rd_req   (rd_req),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data),
    .wr_pulse (wr_pulse),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data)
  );

  // Cycles between conversion cycle starts for a rate code
  function automatic logic [31:0] period_for(input logic [2:0] cr);
    logic [31:0] p;
    p = 32'(PERIOD_1HZ_CYCLES);
    case (cr)
      `TMCR_CR_16HZ: period_for = p >> 4;
      `TMCR_CR_8HZ:  period_for = p >> 3;
      `TMCR_CR_4HZ:  period_for = p >> 2;
      `TMCR_CR_2HZ:  period_for = p >> 1;
      default:       period_for = p;
    endcase
  endfunction

  // Remote-channel averaging factor
  function automatic tmcr_avg_t avg_for(input logic [2:0] cr, input logic [3:0] xcfg);
    if (xcfg[`TMCR_XCFG_DA_DIS]) begin
      avg_for = TMCR_AVG_1X;
    end else if (cr == `TMCR_CR_16HZ) begin
      avg_for = TMCR_AVG_1X;
    end else if (!xcfg[`TMCR_XCFG_DEPTH] || cr == `TMCR_CR_8HZ) begin
      avg_for = TMCR_AVG_2X;
    end else begin
      avg_for = TMCR_AVG_4X;
    end
  endfunction

  // Extended format: offset by 64 degrees, negatives clamp to zero
  function automatic logic [10:0] ext_of(input logic [10:0] leg);
    logic [11:0] s;
    s = {leg[10], leg} + `TMCR_EXT_OFFSET;
    ext_of = s[11] ? 11'h000 : s[10:0];
  endfunction

  // Whole-degree byte of a reading
  function automatic logic [7:0] hi_byte(input logic [10:0] v);
    hi_byte = v[10:3];
  endfunction

  // Fraction byte, left-aligned
  function automatic logic [7:0] lo_byte(input logic [2:0] f);
    lo_byte = {f, 5'h00};
  endfunction

  // Register read mux
  always_comb begin
    rd_data = `TMCR_UNDEF_READ;
    case (rd_addr)
      `TMCR_ADDR_INT_HI:  rd_data = hi_byte(r.leg[0]);
      `TMCR_ADDR_INT_LO:  rd_data = lo_byte(r.shadow[0]);
      `TMCR_ADDR_R1_HI:   rd_data = hi_byte(r.leg[1]);
      `TMCR_ADDR_R1_LO:   rd_data = lo_byte(r.shadow[1]);
      `TMCR_ADDR_R2_HI:   rd_data = hi_byte(r.leg[2]);
      `TMCR_ADDR_R2_LO:   rd_data = lo_byte(r.shadow[2]);
      `TMCR_ADDR_X1_HI:   rd_data = hi_byte(r.ext[0]);
      `TMCR_ADDR_X1_LO:   rd_data = lo_byte(r.shadow[3]);
      `TMCR_ADDR_X2_HI:   rd_data = hi_byte(r.ext[1]);
      `TMCR_ADDR_X2_LO:   rd_data = lo_byte(r.shadow[4]);
      `TMCR_ADDR_STATUS: begin
        rd_data                    = `TMCR_STATUS_RESET;
        rd_data[`TMCR_ST_BUSY]     = r.busy;
        rd_data[`TMCR_ST_WARMER]   = r.warmer & r.xcfg[`TMCR_XCFG_WARMER];
        rd_data[`TMCR_ST_R2_FAULT] = r.r2_fault;
        rd_data[`TMCR_ST_R1_FAULT] = r.r1_fault;
      end
      `TMCR_ADDR_CFG_RD:  rd_data = {1'b0, r.standby, 3'h0, r.cr};
      `TMCR_ADDR_XCFG:    rd_data = {4'h0, r.xcfg};
      `TMCR_ADDR_ONESHOT: rd_data = `TMCR_ONESHOT_READ;
      default:            rd_data = `TMCR_UNDEF_READ;
    endcase
  end

  // Warmer-of-two selection for the remote 2 result
  always_comb begin
    r2_hotter = $signed(meas_result) > $signed(r.r1_last);
    r2_value  = meas_result;
    if (r.xcfg[`TMCR_XCFG_WARMER] && !r.r1_fault && !r2_hotter) begin
      r2_value = r.r1_last;
    end
  end

  always_comb begin
    nx          = r;
    nx.meas_req = 1'b0;
    tick        = 1'b0;
    oneshot     = 1'b0;

    // Interlock: low byte snapshot taken on high-byte read
    if (rd_req) begin
      case (rd_addr)
        `TMCR_ADDR_INT_HI: nx.shadow[0] = r.leg[0][2:0];
        `TMCR_ADDR_R1_HI:  nx.shadow[1] = r.leg[1][2:0];
        `TMCR_ADDR_R2_HI:  nx.shadow[2] = r.leg[2][2:0];
        `TMCR_ADDR_X1_HI:  nx.shadow[3] = r.ext[0][2:0];
        `TMCR_ADDR_X2_HI:  nx.shadow[4] = r.ext[1][2:0];
        default: ;
      endcase
    end

    // Host writes; status and read-only addresses fall to default
    if (wr_pulse) begin
      case (wr_addr)
        `TMCR_ADDR_CFG_WR: begin
          nx.standby = wr_data[`TMCR_CFG_STANDBY];
          nx.cr      = wr_data[2:0];
        end
        `TMCR_ADDR_XCFG:    nx.xcfg = wr_data[3:0];
        `TMCR_ADDR_ONESHOT: oneshot = 1'b1;
        default: ;
      endcase
    end

    // Rate timer, held cleared in standby
    if (r.standby) begin
      nx.timer = '0;
    end else if (r.timer == 32'h0) begin
      tick     = 1'b1;
      nx.timer = period_for(r.cr) - 32'h1;
    end else begin
      nx.timer = r.timer - 32'h1;
    end

    start = (tick | oneshot) & (r.seq == TMCR_SEQ_IDLE);

    case (r.seq)
      TMCR_SEQ_IDLE: begin
        if (start) begin
          nx.busy         = 1'b1;
          nx.chan         = TMCR_CH_INT;
          nx.meas_req     = 1'b1;
          nx.meas_channel = TMCR_CH_INT;
          nx.meas_avg     = TMCR_AVG_1X;
          nx.meas_rec_en  = 1'b0;
          nx.seq          = TMCR_SEQ_WAIT;
        end
      end
      TMCR_SEQ_WAIT: begin
        if (meas_done) begin
          case (r.chan)
            TMCR_CH_INT: begin
              nx.leg[0] = meas_result;
            end
            TMCR_CH_R1: begin
              nx.r1_fault = meas_fault;
              if (!meas_fault) begin
                nx.leg[1]  = meas_result;
                nx.ext[0]  = ext_of(meas_result);
                nx.r1_last = meas_result;
              end
            end
            default: begin
              nx.r2_fault = meas_fault;
              if (!meas_fault) begin
                nx.leg[2] = r2_value;
                nx.ext[1] = ext_of(r2_value);
                nx.warmer = r.xcfg[`TMCR_XCFG_WARMER] & !r.r1_fault & r2_hotter;
              end
            end
          endcase
          if (r.chan == TMCR_CH_R2) begin
            nx.busy = 1'b0;
            nx.seq  = TMCR_SEQ_IDLE;
          end else begin
            nx.chan         = (r.chan == TMCR_CH_INT) ? TMCR_CH_R1 : TMCR_CH_R2;
            nx.meas_req     = 1'b1;
            nx.meas_channel = nx.chan;
            nx.meas_avg     = avg_for(r.cr, r.xcfg);
            nx.meas_rec_en  = r.xcfg[`TMCR_XCFG_REC];
          end
        end
      end
      default: begin
        nx.seq  = TMCR_SEQ_IDLE;
        nx.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r         <= '0;
      r.standby <= CFG_RST[`TMCR_CFG_STANDBY];
      r.cr      <= CFG_RST[2:0];
      r.xcfg    <= XCFG_RST[3:0];
    end else if (ce) begin
      r <= nx;
    end
  end

  assign sda_out      = 1'b0;
  assign meas_req     = r.meas_req & ce;
  assign meas_channel = r.meas_channel;
  assign meas_avg     = r.meas_avg;
  assign meas_rec_en  = r.meas_rec_en;

endmodule // tmcr_temp_monitor

/* dv/tmcr_asserts.sv */
// Port assertions for the temperature monitor's bus and measurement sides
`timescale 1ns/1ns
module tmcr_asserts #(
  parameter int unsigned PERIOD_1HZ_CYCLES = 512
) (
  input wire logic        clk,           // Clock
  input wire logic        reset_n,       // Reset, active low
  input wire logic        ce,            // Clock enable
  input wire logic        scl_in,        // Bus clock
  input wire logic        sda_in,        // Bus data
  input wire logic        sda_out,       // Data drive level
  input wire logic        sda_oe_n,      // Data drive, active low
  input wire logic        meas_req,      // Measure request
  input wire logic [1:0]  meas_channel,  // Channel
  input wire logic [1:0]  meas_avg,      // Averaging code
  input wire logic        meas_rec_en,   // Correction on
  input wire logic        meas_done,     // Measure done
  input wire logic [10:0] meas_result,   // Reading
  input wire logic        meas_fault     // Diode fault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_drive_level: assert property (sda_out == 1'b0) else $error("data drive level high");
  a_req_pulse: assert property (meas_req && !meas_done |=> !meas_req)
    else $error("request too long");
  a_int_plain: assert property (meas_req && meas_channel == 2'h0 |-> !meas_rec_en &&
    meas_avg == 2'h0) else $error("internal channel averaged or corrected");
  a_seq_remote1: assert property (meas_done && meas_channel == 2'h0 |=>
    meas_req && meas_channel == 2'h1) else $error("remote 1 not requested next");
  a_seq_remote2: assert property (meas_done && meas_channel == 2'h1 |=>
    meas_req && meas_channel == 2'h2) else $error("remote 2 not requested next");
  a_seq_end: assert property (meas_done && meas_channel == 2'h2 |=> !meas_req [*2])
    else $error("request after last channel");
  a_chan_hold: assert property (!meas_req |-> $stable(meas_channel) && $stable(meas_avg))
    else $error("channel or averaging changed without request");
  a_ack_in_low: assert property ($fell(sda_oe_n) |-> $past(scl_in) == 1'b0)
    else $error("data driven while bus clock high");
  a_release_in_low: assert property ($rose(sda_oe_n) |-> $past(scl_in) == 1'b0)
    else $error("data released while bus clock high");
  a_reset_quiet: assert property ($rose(reset_n) |-> sda_oe_n && !meas_req)
    else $error("outputs active after reset");
  c_full_cycle: cover property (meas_done && meas_channel == 2'h2);
  c_ack: cover property ($fell(sda_oe_n));
  c_fault: cover property (meas_done && meas_fault);
endmodule // tmcr_asserts

bind tmcr_temp_monitor tmcr_asserts #(.PERIOD_1HZ_CYCLES(PERIOD_1HZ_CYCLES)) u_asserts (
  .clk(clk), .reset_n(reset_n), .ce(ce), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .meas_req(meas_req), .meas_channel(meas_channel), .meas_avg(meas_avg),
  .meas_rec_en(meas_rec_en), .meas_done(meas_done), .meas_result(meas_result),
  .meas_fault(meas_fault));

/* dv/tmcr_host_model.sv */
// Two-wire bus host model for the monitor's management pins
`timescale 1ns/1ns
`include "tmcr_defs.svh"
module tmcr_host_model (
  input  wire logic clk,      // System clock
  input  wire logic sda,      // Resolved data line
  output logic      scl,      // Bus clock, high when idle
  output logic      sda_pull  // Pulls data line low
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Four clocks low, four high
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    tick(2);
    sda_pull = ~b;
    tick(2);
    scl = 1'b1;
    tick(4);
    r = sda;
  endtask
  // Data edge while clock high: start is (0,1), stop is (1,0)
  task automatic cond(input logic a, input logic b);
    scl = 1'b0;
    tick(2);
    sda_pull = a;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_pull = b;
    tick(4);
  endtask
  task automatic send(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ok = ok & ~r;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    cond(1'b0, 1'b1);
    send({`TMCR_DEV_ADDR, 1'b0}, ok);
    send(a, ok);
    send(d, ok);
    cond(1'b1, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic r;
    ok = 1'b1;
    cond(1'b0, 1'b1);
    send({`TMCR_DEV_ADDR, 1'b0}, ok);
    send(a, ok);
    cond(1'b0, 1'b1);
    send({`TMCR_DEV_ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
    cond(1'b1, 1'b0);
  endtask
endmodule // tmcr_host_model

/* dv/tb_tmcr_temp_monitor.sv */
// Self-checking bench for the temperature monitor registers
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb_tmcr_temp_monitor;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        meas_done = 1'b0;
  logic        meas_fault = 1'b0;
  logic [10:0] meas_result = 11'h000;
  logic        scl, sda_pull, sda_oe_n, sda_out, meas_req, meas_rec_en;
  logic [1:0]  meas_channel, meas_avg, ch;
  logic [10:0] res [3] = '{11'h123, 11'h0a5, 11'h1f0};
  logic        flt [3] = '{1'b0, 1'b0, 1'b0};
  logic [1:0]  avg_seen [3];
  logic        rec_seen [3];
  int          n_mismatch = 0, tests_run = 0, n_meas = 0, lat = 0, per = 0;
  time         t0 = 0;
  wire         sda = ~(sda_pull | ~sda_oe_n);
  always #50 clk = ~clk;
  tmcr_temp_monitor #(.PERIOD_1HZ_CYCLES(512)) DUT (
    .clk(clk), .reset_n(reset_n), .ce(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .meas_req(meas_req), .meas_channel(meas_channel), .meas_avg(meas_avg),
    .meas_rec_en(meas_rec_en), .meas_done(meas_done), .meas_result(meas_result),
    .meas_fault(meas_fault));
  tmcr_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  // Front end: answers each request after lat cycles
  initial forever begin
    @(posedge clk);
    #1;
    while (meas_req === 1'b1) begin
      ch = meas_channel;
      avg_seen[ch] = meas_avg;
      rec_seen[ch] = meas_rec_en;
      if (ch == 2'h0) begin
        per = int'(($time - t0) / 100);
        t0 = $time;
      end
      repeat (lat) begin
        @(posedge clk);
        #1;
      end
      meas_result = res[ch];
      meas_fault = flt[ch];
      meas_done = 1'b1;
      @(posedge clk);
      #1;
      meas_done = 1'b0;
      meas_result = ~meas_result;
      n_meas++;
    end
  end
  task automatic ws(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.wr(a, d, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask
  task automatic rp(input logic [7:0] ah, input logic [7:0] al, input logic [10:0] v);
    rc(ah, v[10:3]);
    rc(al, {v[2:0], 5'h00});
  endtask
  task automatic conv(input int l);
    int n0;
    n0 = n_meas;
    lat = l;
    ws(8'h0f, 8'h5a);
    if (l > 0) rc(8'h02, 8'h80);
    for (int i = 0; i < 5000 && n_meas < n0 + 3; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
    `CHK(n_meas, n0 + 3)
    lat = 0;
  endtask
  task automatic t_access;
    rc(8'h02, 8'h00);
    rc(8'h03, 8'h45);
    rc(8'h04, 8'h09);
    rc(8'h0f, 8'h00);
    ws(8'h02, 8'hff);
    rc(8'h02, 8'h00);
    ws(8'h03, 8'h00);
    rc(8'h03, 8'h45);
    ws(8'h05, 8'ha5);
    rc(8'h05, 8'h00);
    ws(8'h04, 8'hf0);
    rc(8'h04, 8'h00);
    ws(8'h04, 8'h09);
    $display("test t_access done");
  endtask
  task automatic t_oneshot;
    int n0;
    conv(0);
    rp(8'h00, 8'h23, res[0]);
    rp(8'h01, 8'h10, res[1]);
    rp(8'hf8, 8'hf9, res[2]);
    rp(8'hfa, 8'hfb, res[1] + 11'h200);
    rp(8'hfc, 8'hfd, res[2] + 11'h200);
    rc(8'h02, 8'h00);
    `CHK(avg_seen[1], 2'h2)
    `CHK(rec_seen[2], 1'b1)
    n0 = n_meas;
    repeat (600) @(posedge clk);
    #1;
    `CHK(n_meas, n0)
    $display("test t_oneshot done");
  endtask
  task automatic t_fault;
    flt[1] = 1'b1;
    res[1] = 11'h055;
    conv(500);
    rc(8'h02, 8'h01);
    rp(8'h01, 8'h10, 11'h0a5);
    flt = '{1'b0, 1'b0, 1'b1};
    res = '{11'h123, 11'h0a5, 11'h050};
    conv(0);
    rc(8'h02, 8'h02);
    rp(8'hf8, 8'hf9, 11'h1f0);
    flt[2] = 1'b0;
    $display("test t_fault done");
  endtask
  task automatic t_warmer;
    ws(8'h04, 8'h0b);
    conv(0);
    rc(8'h02, 8'h00);
    rp(8'hf8, 8'hf9, 11'h0a5);
    res[2] = 11'h1f0;
    conv(0);
    rc(8'h02, 8'h10);
    rp(8'hf8, 8'hf9, 11'h1f0);
    rp(8'h01, 8'h10, 11'h0a5);
    ws(8'h04, 8'h09);
    $display("test t_warmer done");
  endtask
  task automatic t_latch;
    logic [7:0] d;
    logic ok;
    host.rd(8'h01, d, ok);
    `CHK(d, 8'h14)
    res[1] = 11'h0a2;
    conv(0);
    rc(8'h10, 8'ha0);
    rp(8'h01, 8'h10, 11'h0a2);
    $display("test t_latch done");
  endtask
  task automatic run_at(input logic [2:0] c, input logic [1:0] ea, input logic er);
    int p;
    p = 512 >> (c - 3);
    ws(8'h09, {5'h08, c});
    ws(8'h09, {5'h00, c});
    rc(8'h03, {5'h00, c});
    repeat (3 * p + 50) @(posedge clk);
    #1;
    `CHK(per, p)
    `CHK(avg_seen[1], ea)
    `CHK(avg_seen[2], ea)
    `CHK(rec_seen[1], er)
  endtask
  task automatic t_run;
    int n0;
    run_at(3'h3, 2'h2, 1'b1);
    run_at(3'h4, 2'h2, 1'b1);
    run_at(3'h5, 2'h2, 1'b1);
    run_at(3'h6, 2'h1, 1'b1);
    run_at(3'h7, 2'h0, 1'b1);
    ws(8'h04, 8'h01);
    run_at(3'h5, 2'h1, 1'b1);
    ws(8'h04, 8'h0c);
    run_at(3'h5, 2'h0, 1'b0);
    ws(8'h09, 8'h45);
    n0 = n_meas;
    repeat (600) @(posedge clk);
    #1;
    `CHK(n_meas, n0)
    ws(8'h04, 8'h09);
    $display("test t_run done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    t_access();
    t_oneshot();
    t_fault();
    t_warmer();
    t_latch();
    t_run();
    test_done();
  end
  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule // tb_tmcr_temp_monitor
